// [core/dpgio_regs.vh]
`ifndef DPGIO_REGS_VH
`define DPGIO_REGS_VH

// register offsets
`define DPGIO_A_DATA_ADDR 8'h05
`define DPGIO_B_DATA_ADDR 8'h06
`define DPGIO_INT_CTRL_ADDR 8'h0b
`define DPGIO_OPTION_ADDR 8'h81
`define DPGIO_A_DIR_ADDR 8'h85
`define DPGIO_B_DIR_ADDR 8'h86
`define DPGIO_ANA_CFG_ADDR 8'h9f

// field positions
`define DPGIO_OPT_PULLUP_N_BIT 7
`define DPGIO_OPT_T0_EXT_BIT 5
`define DPGIO_INT_CHG_EN_BIT 3
`define DPGIO_INT_CHG_FLAG_BIT 0
`define DPGIO_A_OD_BIT 4

// reset values
`define DPGIO_A_DATA_RST 5'h00
`define DPGIO_B_DATA_RST 8'h00
`define DPGIO_OPTION_RST 8'hff
`define DPGIO_A_DIR_RST 5'h1f
`define DPGIO_B_DIR_RST 8'hff
`define DPGIO_ANA_CFG_RST 2'h0

// analog pin configuration field encodings
`define DPGIO_CFG_ALL_ANALOG 2'h0
`define DPGIO_CFG_ANALOG_VREF 2'h1
`define DPGIO_CFG_TWO_ANALOG 2'h2
`define DPGIO_CFG_ALL_DIGITAL 2'h3

// timing counts
`define DPGIO_SYNC_STAGES 2

`endif

// [core/dpgio_core.v]
// How it works
// - port A keeps a five-bit output latch
// - direction bit set means driver off
// - port A read gives pins, write latch
// - port writes store the written data in the latch
// - bit four is open-drain, never drives high
// - bit four also feeds timer clock
// - two-bit field picks analog or digital
// - reset makes shared pins analog, read zero
// - direction bits steer drivers even analog
// - peripheral-owned pins leave general-purpose use
// - port B eight bits with direction register
// - option bit seven low enables pull-ups
// - output pins lose their pull-up
// - reset leaves port B pull-ups off
// - only input bits four-seven are compared
// - mismatches ORed into change flag bit
// - change condition can wake from halt
// - mismatch keeps setting flag until port access
// - variant may miss change during read
// - both direction registers reset to ones
// - change flag sticks until software clears
// - enable bit gates change interrupt
// - flag sets regardless of enable
`include "dpgio_regs.vh"
`default_nettype none

module dpgio_core #(
    parameter LOSE_CHANGE_ON_READ = 0
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // port A pins
    input wire [4:0] pa_in,
    output reg [4:0] pa_out,
    output reg [4:0] pa_oe,
    output reg [3:0] pa_analog_sel,
    output reg timer_ext_clk,
    // port B pins
    input wire [7:0] pb_in,
    output reg [7:0] pb_out,
    output reg [7:0] pb_oe,
    output reg [7:0] pb_pullup_en,
    // change interrupt and wake request
    output reg change_irq
);

    function [3:0] analog_mask;
        input [1:0] cfg;
        begin
            case (cfg)
                `DPGIO_CFG_ALL_ANALOG: analog_mask = 4'hf;
                `DPGIO_CFG_ANALOG_VREF: analog_mask = 4'hf;
                `DPGIO_CFG_TWO_ANALOG: analog_mask = 4'h3;
                `DPGIO_CFG_ALL_DIGITAL: analog_mask = 4'h0;
                default: analog_mask = 4'hf;
            endcase
        end
    endfunction

    reg [4:0] pa_meta_q;
    reg [4:0] pa_sync_q;
    reg [7:0] pb_meta_q;
    reg [7:0] pb_sync_q;
    reg [4:0] a_latch_q;
    reg [4:0] a_latch_d;
    reg [7:0] b_latch_q;
    reg [7:0] b_latch_d;
    reg [4:0] a_dir_q;
    reg [7:0] b_dir_q;
    reg [7:0] option_q;
    reg [1:0] ana_cfg_q;
    reg chg_en_q;
    reg chg_flag_q;
    reg chg_flag_d;
    reg [3:0] cmp_q;
    reg [7:0] rdata_d;
    reg [4:0] pa_oe_d;
    reg [4:0] pa_out_d;

    wire wr_a = reg_wr && (reg_addr == `DPGIO_A_DATA_ADDR);
    wire wr_b = reg_wr && (reg_addr == `DPGIO_B_DATA_ADDR);
    wire rd_b = reg_rd && (reg_addr == `DPGIO_B_DATA_ADDR);
    wire wr_int = reg_wr && (reg_addr == `DPGIO_INT_CTRL_ADDR);
    wire [3:0] ana_mask = analog_mask(ana_cfg_q);
    wire t0_owns_pin = option_q[`DPGIO_OPT_T0_EXT_BIT];
    // digital view of port A: analog pins read zero
    wire [4:0] a_pins = pa_sync_q & {1'b1, ~ana_mask};
    // only input pins of the upper nibble are compared
    wire [3:0] mismatch = (pb_sync_q[7:4] ^ cmp_q) & b_dir_q[7:4];
    wire b_access = rd_b || wr_b;

    // two-stage input synchronisers
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pa_meta_q <= 5'h00;
            pa_sync_q <= 5'h00;
            pb_meta_q <= 8'h00;
            pb_sync_q <= 8'h00;
        end else begin
            pa_meta_q <= pa_in;
            pa_sync_q <= pa_meta_q;
            pb_meta_q <= pb_in;
            pb_sync_q <= pb_meta_q;
        end
    end

    // port latches: a write stores the register write data
    always @* begin
        a_latch_d = a_latch_q;
        b_latch_d = b_latch_q;
        if (wr_a) begin
            a_latch_d = reg_wdata[4:0];
        end
        if (wr_b) begin
            b_latch_d = reg_wdata;
        end
    end

    // change flag: set wins over a software clear
    always @* begin
        chg_flag_d = chg_flag_q;
        if (wr_int) begin
            chg_flag_d = reg_wdata[`DPGIO_INT_CHG_FLAG_BIT];
        end
        if (|mismatch && !(LOSE_CHANGE_ON_READ != 0 && rd_b)) begin
            chg_flag_d = 1'b1;
        end
    end

    // port A drivers
    always @* begin
        pa_oe_d = ~a_dir_q;
        pa_out_d = a_latch_q;
        // open-drain bit pulls low only, and yields to the timer input
        pa_out_d[`DPGIO_A_OD_BIT] = 1'b0;
        pa_oe_d[`DPGIO_A_OD_BIT] = ~a_dir_q[`DPGIO_A_OD_BIT]
            & ~a_latch_q[`DPGIO_A_OD_BIT] & ~t0_owns_pin;
    end

    // read mux
    always @* begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `DPGIO_A_DATA_ADDR: rdata_d = {3'h0, a_pins};
                `DPGIO_B_DATA_ADDR: rdata_d = pb_sync_q;
                `DPGIO_INT_CTRL_ADDR: begin
                    rdata_d[`DPGIO_INT_CHG_EN_BIT] = chg_en_q;
                    rdata_d[`DPGIO_INT_CHG_FLAG_BIT] = chg_flag_q;
                end
                `DPGIO_OPTION_ADDR: rdata_d = option_q;
                `DPGIO_A_DIR_ADDR: rdata_d = {3'h0, a_dir_q};
                `DPGIO_B_DIR_ADDR: rdata_d = b_dir_q;
                `DPGIO_ANA_CFG_ADDR: rdata_d = {6'h00, ana_cfg_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // registers
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_latch_q <= `DPGIO_A_DATA_RST;
            b_latch_q <= `DPGIO_B_DATA_RST;
            a_dir_q <= `DPGIO_A_DIR_RST;
            b_dir_q <= `DPGIO_B_DIR_RST;
            option_q <= `DPGIO_OPTION_RST;
            ana_cfg_q <= `DPGIO_ANA_CFG_RST;
            chg_en_q <= 1'b0;
            chg_flag_q <= 1'b0;
            cmp_q <= 4'h0;
        end else begin
            a_latch_q <= a_latch_d;
            b_latch_q <= b_latch_d;
            chg_flag_q <= chg_flag_d;
            if (reg_wr && reg_addr == `DPGIO_A_DIR_ADDR) begin
                a_dir_q <= reg_wdata[4:0];
            end
            if (reg_wr && reg_addr == `DPGIO_B_DIR_ADDR) begin
                b_dir_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `DPGIO_OPTION_ADDR) begin
                option_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `DPGIO_ANA_CFG_ADDR) begin
                ana_cfg_q <= reg_wdata[1:0];
            end
            if (wr_int) begin
                chg_en_q <= reg_wdata[`DPGIO_INT_CHG_EN_BIT];
            end
            // any port B access re-latches the comparison value
            if (b_access) begin
                cmp_q <= pb_sync_q[7:4];
            end
        end
    end

    // registered outputs
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            pa_out <= 5'h00;
            pa_oe <= 5'h00;
            pa_analog_sel <= 4'hf;
            timer_ext_clk <= 1'b0;
            pb_out <= 8'h00;
            pb_oe <= 8'h00;
            pb_pullup_en <= 8'h00;
            change_irq <= 1'b0;
        end else begin
            reg_rdata <= rdata_d;
            pa_out <= pa_out_d;
            pa_oe <= pa_oe_d;
            pa_analog_sel <= ana_mask;
            timer_ext_clk <= pa_sync_q[`DPGIO_A_OD_BIT];
            pb_out <= b_latch_q;
            pb_oe <= ~b_dir_q;
            // pull-ups only on input pins, all switched by one bit
            pb_pullup_en <= {8{~option_q[`DPGIO_OPT_PULLUP_N_BIT]}} & b_dir_q;
            change_irq <= chg_flag_q & chg_en_q;
        end
    end

endmodule

`default_nettype wire

// [tb/dpgio_core_monitor.sv]
`include "dpgio_regs.vh"
`default_nettype none
module dpgio_core_mon (
    // clock, reset, register port
    input wire mclk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // pin side
    input wire [4:0] pa_out,
    input wire [4:0] pa_oe,
    input wire [3:0] pa_analog_sel,
    input wire [7:0] pb_oe,
    input wire [7:0] pb_pullup_en,
    input wire change_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire wr_ictl = reg_wr && reg_addr == `DPGIO_INT_CTRL_ADDR;
    chk_a4_never_high: assert property (!(pa_oe[4] && pa_out[4]))
        else $error("pin a4 driven high");
    chk_pullup_outputs: assert property ((pb_pullup_en & pb_oe) == 8'h00)
        else $error("pull-up on output pin");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    chk_irq_held: assert property (change_irq && !wr_ictl
        |=> change_irq || $past(wr_ictl, 2)) else $error("change irq dropped");
    chk_dir_a: assert property (reg_wr && reg_addr == `DPGIO_A_DIR_ADDR
        |-> ##2 pa_oe[3:0] == ~$past(reg_wdata[3:0], 2)) else $error("a enable");
    chk_dir_b: assert property (reg_wr && reg_addr == `DPGIO_B_DIR_ADDR
        |-> ##2 pb_oe == ~$past(reg_wdata, 2)) else $error("b enable");
    chk_latch_a: assert property (reg_wr && reg_addr == `DPGIO_A_DATA_ADDR
        |-> ##2 pa_out[3:0] == $past(reg_wdata[3:0], 2)) else $error("a drive");
    chk_reset_state: assert property ($past(rst) |-> pa_oe == 5'h00
        && pb_oe == 8'h00 && pb_pullup_en == 8'h00 && pa_analog_sel == 4'hf)
        else $error("state after reset");
endmodule
bind dpgio_core dpgio_core_mon u_dpgio_core_mon (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pa_out, .pa_oe, .pa_analog_sel, .pb_oe, .pb_pullup_en, .change_irq);
`default_nettype wire

// [tb/dpgio_pin_model.sv]
`default_nettype none
module dpgio_pin_model (
    // design drive
    input wire logic [4:0] pa_out,
    input wire logic [4:0] pa_oe,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe,
    // outside circuitry
    input wire logic [4:0] pa_ext,
    input wire logic [7:0] pb_ext,
    // pin levels
    output logic [4:0] pa_pin,
    output logic [7:0] pb_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // a4 only sinks; released pins follow the outside
    assign pa_pin = (pa_oe & {1'b0, pa_out[3:0]}) | (~pa_oe & pa_ext);
    assign pb_pin = (pb_oe & pb_out) | (~pb_oe & pb_ext);
endmodule
`default_nettype wire

// [tb/test_dual_port_gpio_with_change_irq.sv]
`default_nettype none
module test_dual_port_gpio_with_change_irq;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, reg_wr, reg_rd, timer_ext_clk, change_irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pb_out, pb_oe, pb_pullup_en, pb_ext, pb_pin;
    logic [4:0] pa_out, pa_oe, pa_ext, pa_pin;
    logic [3:0] pa_analog_sel;
    int error_cnt = 0;
    int checks_done = 0;
    dpgio_core u_dpgio_core (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pa_in(pa_pin), .pa_out, .pa_oe, .pa_analog_sel, .timer_ext_clk,
        .pb_in(pb_pin), .pb_out, .pb_oe, .pb_pullup_en, .change_irq);
    dpgio_pin_model u_dpgio_pin_model (.pa_out, .pa_oe, .pb_out, .pb_oe, .pa_ext, .pb_ext,
        .pa_pin, .pb_pin);
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // w=1 writes d, w=0 reads and expects d
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!w) chk("read data", reg_rdata, d);
        else repeat (4) @(posedge mclk);
    endtask
    task automatic pins(input logic [4:0] a, input logic [7:0] b);
        @(posedge mclk);
        pa_ext <= a;
        pb_ext <= b;
        repeat (5) @(posedge mclk);
        #1;
    endtask
    task automatic t_reset;
        bus(0, 8'h81, 8'hff);
        bus(0, 8'h85, 8'h1f);
        bus(0, 8'h86, 8'hff);
        bus(0, 8'h40, 8'h00);
        bus(0, 8'h05, 8'h10);
        chk("pull-ups", pb_pullup_en, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_port_a;
        logic [3:0] asel [4] = '{4'hf, 4'hf, 4'h3, 4'h0};
        bus(1, 8'h9f, 8'h03);
        bus(1, 8'h85, 8'h00);
        bus(1, 8'h05, 8'h1f);
        chk("a drive", {3'h0, pa_out}, 8'h0f);
        chk("a enable", {3'h0, pa_oe}, 8'h0f);
        // a4 latch high leaves the open-drain pin released, so the outside level reads back
        bus(0, 8'h05, 8'h1f);
        bus(1, 8'h81, 8'hdf);
        bus(1, 8'h05, 8'h0f);
        bus(0, 8'h05, 8'h0f);
        bus(1, 8'h05, 8'h1f);
        bus(0, 8'h05, 8'h1f);
        chk("timer clock", {7'h0, timer_ext_clk}, 8'h01);
        bus(1, 8'h85, 8'h1f);
        chk("a enable", {3'h0, pa_oe}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            bus(1, 8'h9f, i[7:0]);
            chk("analog select", {4'h0, pa_analog_sel}, {4'h0, asel[i]});
            bus(0, 8'h05, {4'h1, ~asel[i]});
        end
        $display("t_port_a done");
    endtask
    task automatic t_change;
        bus(1, 8'h81, 8'h7f);
        bus(1, 8'h86, 8'h7f);
        chk("b enable", pb_oe, 8'h80);
        chk("pull-ups", pb_pullup_en, 8'h7f);
        bus(1, 8'h06, 8'h80);
        bus(1, 8'h0b, 8'h08);
        pins(5'h10, 8'h08);
        bus(0, 8'h0b, 8'h08);
        pins(5'h10, 8'h28);
        chk("change irq", {7'h0, change_irq}, 8'h01);
        bus(1, 8'h0b, 8'h08);
        bus(0, 8'h0b, 8'h09);
        bus(0, 8'h06, 8'ha8);
        bus(1, 8'h0b, 8'h08);
        bus(0, 8'h0b, 8'h08);
        bus(1, 8'h0b, 8'h00);
        // no port B read until the flag has been seen
        pins(5'h10, 8'h38);
        bus(0, 8'h0b, 8'h01);
        chk("change irq", {7'h0, change_irq}, 8'h00);
        $display("t_change done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0};
        {pa_ext, pb_ext} = {5'h1f, 8'h00};
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_port_a;
        t_change;
        test_done;
    end
    initial begin
        #40000;
        error_cnt++;
        test_done;
    end
endmodule
`default_nettype wire
